/* hdl/msg_front_consts.svh */
// Purpose: named constants of the remote message front end
// Assumes: 25 MHz system clock, 32-bit AHB-Lite register port
// Notes: byte addresses of the software registers
`ifndef MSG_FRONT_CONSTS_SVH
`define MSG_FRONT_CONSTS_SVH
`define OFS_CTRL 12'h000
`define OFS_GAP 12'h004
`define OFS_IDLE 12'h008
`define OFS_LIMLO 12'h00c
`define OFS_LIMHI 12'h010
`define OFS_SETVAL 12'h014
`define OFS_STATUS 12'h018
`define OFS_ERRQ 12'h01c
`define OFS_SEQ_START 12'h020
`define OFS_SEQ_END 12'h024
`define OFS_SEQ_TIME 12'h028
`define OFS_SEQ_RATED 12'h02c
`define OFS_SEQ_RES 12'h030
`define RST_GAP_CYC 32'h0000c350
`define RST_IDLE_CYC 32'h07735940
`define CODE_FULL 16'hcccc
`define MBUS_ADDR 8'h00
`define BYTE_LAST_ERR 8'h29
`define BYTE_SCPI 8'h2a
`define CHR_LF 8'h0a
`define CHR_CR 8'h0d
`define MIN_SLOPE_NUM 32'd725
`define MIN_SLOPE_DEN 32'd1000000
`define ERR_FRAME 3'd0
`define ERR_MBUS 3'd1
`define ERR_LIMIT 3'd2
`define ERR_SLOPE 3'd3
`define ERR_PORT 3'd4
`define CTRL_GPIB 1'b1
`endif

/* hdl/msg_front_pkg.sv */
// Purpose: types of the remote message front end
// Assumes: nothing beyond the constants header
// Notes: port kinds select framing
package msg_front_pkg;
	typedef enum logic [1:0] {
		PORT_USB = 2'b00,
		PORT_NET = 2'b01,
		PORT_MTCP = 2'b10,
		PORT_GPIB = 2'b11
	} port_kind_e;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_BODY = 2'b01,
		ST_DONE = 2'b10
	} rx_state_e;
	typedef enum logic [1:0] {
		PROTO_NONE = 2'b00,
		PROTO_BIN = 2'b01,
		PROTO_TEXT = 2'b10,
		PROTO_MTCP = 2'b11
	} proto_e;
endpackage

/* hdl/remote_message_front_end.sv */
// Purpose: message framing, protocol choice and set value checks
// Assumes: bytes arrive synchronous to sys_clk_i with a one-cycle strobe
// Notes: registers on AHB-Lite, zero wait states
//
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`include "msg_front_consts.svh"
module remote_message_front_end
	import msg_front_pkg::*;
#(
	parameter logic [31:0] GAP_CYC = `RST_GAP_CYC,
	parameter logic [31:0] IDLE_CYC = `RST_IDLE_CYC
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_byte_i,
	input wire logic [1:0] rx_port_i,
	input wire logic sock_open_i,
	output logic msg_done_o,
	output logic [1:0] msg_proto_o,
	output logic [7:0] msg_len_o,
	output logic sock_close_o,
	output logic [15:0] applied_code_o
);
	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	logic ap_wr_r, ap_rd_r;
	logic [11:0] ap_ofs_r;
	logic [31:0] gap_r, idle_r, seq_start_r, seq_end_r, seq_time_r, seq_rated_r;
	logic [15:0] lim_lo_r, lim_hi_r, setval_r;
	logic gpib_fit_r;
	logic [4:0] err_sticky_r;
	logic [7:0] err_count_r;
	logic seq_ok_r, seq_bad_r;
	logic [31:0] rd_mux;
	wire take = hsel_i & hready_i & htrans_i[1];
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ap_wr_r <= 1'b0;
			ap_rd_r <= 1'b0;
			ap_ofs_r <= 12'h000;
		end else begin
			ap_wr_r <= take & hwrite_i;
			ap_rd_r <= take & ~hwrite_i;
			ap_ofs_r <= haddr_i[11:0];
		end
	end
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	wire wr_ctrl = ap_wr_r && ap_ofs_r == `OFS_CTRL;
	wire wr_gap = ap_wr_r && ap_ofs_r == `OFS_GAP;
	wire wr_idle = ap_wr_r && ap_ofs_r == `OFS_IDLE;
	wire wr_lo = ap_wr_r && ap_ofs_r == `OFS_LIMLO;
	wire wr_hi = ap_wr_r && ap_ofs_r == `OFS_LIMHI;
	wire wr_set = ap_wr_r && ap_ofs_r == `OFS_SETVAL;
	wire wr_sst = ap_wr_r && ap_ofs_r == `OFS_SEQ_START;
	wire wr_sen = ap_wr_r && ap_ofs_r == `OFS_SEQ_END;
	wire wr_stm = ap_wr_r && ap_ofs_r == `OFS_SEQ_TIME;
	wire wr_srt = ap_wr_r && ap_ofs_r == `OFS_SEQ_RATED;
	wire rd_errq = ap_rd_r && ap_ofs_r == `OFS_ERRQ;
	// limit check: in range when lo <= v <= hi and v within full scale
	wire [15:0] wval = hwdata_i[15:0];
	wire set_ok = wval >= lim_lo_r && wval <= lim_hi_r && wval <= `CODE_FULL;
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			gap_r <= GAP_CYC;
			idle_r <= IDLE_CYC;
			lim_lo_r <= 16'h0000;
			lim_hi_r <= `CODE_FULL;
			setval_r <= 16'h0000;
			gpib_fit_r <= 1'b0;
			seq_start_r <= 32'h00000000;
			seq_end_r <= 32'h00000000;
			seq_time_r <= 32'h00000001;
			seq_rated_r <= 32'h00000000;
		end else begin
			if (wr_ctrl) gpib_fit_r <= hwdata_i[0];
			if (wr_gap) gap_r <= hwdata_i;
			if (wr_idle) idle_r <= hwdata_i;
			if (wr_lo) lim_lo_r <= wval;
			if (wr_hi) lim_hi_r <= wval;
			if (wr_set && set_ok) setval_r <= wval;
			if (wr_sst) seq_start_r <= hwdata_i;
			if (wr_sen) seq_end_r <= hwdata_i;
			if (wr_stm) seq_time_r <= hwdata_i;
			if (wr_srt) seq_rated_r <= hwdata_i;
		end
	end
	// converter takes 15 significant bits: adjacent codes pair up
	assign applied_code_o = {setval_r[15:1], 1'b0};
	// ----------------------------------------
	// sequence point slope check
	// ----------------------------------------
	// slope*time compared to min slope: |end-start|*1e6 >= 725*rated*time
	wire [31:0] dlt = seq_end_r >= seq_start_r ? seq_end_r - seq_start_r
		: seq_start_r - seq_end_r;
	wire [63:0] lhs = 64'(dlt) * 64'(`MIN_SLOPE_DEN);
	wire [63:0] rhs = 64'(seq_rated_r) * 64'(`MIN_SLOPE_NUM) * 64'(seq_time_r);
	wire rng_bad = seq_start_r > 32'(`CODE_FULL) || seq_end_r > 32'(`CODE_FULL);
	wire slope_bad = dlt != 32'h0 && lhs < rhs;
	wire seq_eval = wr_stm;
	logic seq_eval_r;
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			seq_eval_r <= 1'b0;
			seq_ok_r <= 1'b0;
			seq_bad_r <= 1'b0;
		end else begin
			seq_eval_r <= seq_eval;
			if (seq_eval_r) begin
				seq_ok_r <= ~(slope_bad | rng_bad);
				seq_bad_r <= slope_bad | rng_bad;
			end
		end
	end
	// ----------------------------------------
	// message framing
	// ----------------------------------------
	rx_state_e st_r;
	proto_e proto_r;
	logic [31:0] gap_cnt_r, idle_cnt_r;
	logic [7:0] len_r;
	logic bad_r, done_r;
	logic [1:0] port_r;
	wire first = rx_valid_i && st_r != ST_BODY;
	wire is_mtcp = rx_port_i == PORT_MTCP;
	wire txt_first = rx_byte_i >= `BYTE_SCPI;
	wire bin_first = rx_byte_i == `MBUS_ADDR;
	wire mbus_err = rx_byte_i != 8'h00 && rx_byte_i <= `BYTE_LAST_ERR;
	wire gpib_bin = rx_port_i == PORT_GPIB && !txt_first;
	proto_e first_proto;
	// reserved port: header precedes everything, so no sniffing
	assign first_proto = is_mtcp ? PROTO_MTCP : (txt_first ? PROTO_TEXT : PROTO_BIN);
	wire term = rx_valid_i && proto_r == PROTO_TEXT && st_r == ST_BODY
		&& (rx_byte_i == `CHR_LF || rx_byte_i == `CHR_CR);
	wire term_first = first && first_proto == PROTO_TEXT
		&& (rx_byte_i == `CHR_LF || rx_byte_i == `CHR_CR);
	wire gap_out = st_r == ST_BODY && !rx_valid_i && gap_cnt_r >= gap_r;
	// reserved port: any nonzero first byte is flagged, only a zero may open a message
	wire port_err = first && is_mtcp && (txt_first || mbus_err);
	wire first_err = first && !is_mtcp && (mbus_err || gpib_bin || term_first);
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			st_r <= ST_IDLE;
			proto_r <= PROTO_NONE;
			gap_cnt_r <= 32'h0;
			len_r <= 8'h00;
			bad_r <= 1'b0;
			done_r <= 1'b0;
			port_r <= 2'b00;
		end else begin
			done_r <= 1'b0;
			case (st_r)
				ST_IDLE, ST_DONE: begin
					gap_cnt_r <= 32'h0;
					st_r <= ST_IDLE;
					if (rx_valid_i) begin
						st_r <= ST_BODY;
						proto_r <= first_proto;
						port_r <= rx_port_i;
						len_r <= 8'h01;
						bad_r <= port_err | first_err;
					end
				end
				ST_BODY: begin
					if (rx_valid_i) begin
						gap_cnt_r <= 32'h0;
						len_r <= len_r + 8'h01;
					end else begin
						gap_cnt_r <= gap_cnt_r + 32'h1;
					end
					if (term || gap_out) begin
						st_r <= ST_DONE;
						gap_cnt_r <= 32'h0;
						done_r <= ~bad_r;
					end
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end
	assign msg_done_o = done_r;
	assign msg_proto_o = proto_r;
	assign msg_len_o = len_r;
	// ----------------------------------------
	// connection timeout
	// ----------------------------------------
	logic close_r;
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			idle_cnt_r <= 32'h0;
			close_r <= 1'b0;
		end else begin
			close_r <= 1'b0;
			// a fresh socket starts from zero, so reconnect is always possible
			if (!sock_open_i || rx_valid_i) begin
				idle_cnt_r <= 32'h0;
			end else if (idle_cnt_r >= idle_r - 32'h1) begin
				idle_cnt_r <= 32'h0;
				close_r <= 1'b1;
			end else begin
				idle_cnt_r <= idle_cnt_r + 32'h1;
			end
		end
	end
	assign sock_close_o = close_r;
	// ----------------------------------------
	// error flags, held until queried
	// ----------------------------------------
	wire frame_err_ev = st_r == ST_BODY && (term || gap_out) && bad_r;
	wire [4:0] err_ev = {port_err, seq_eval_r & (slope_bad | rng_bad),
		wr_set & ~set_ok, first_err & mbus_err, frame_err_ev};
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			err_sticky_r <= 5'h00;
			err_count_r <= 8'h00;
		end else begin
			// set wins over the read-clear
			err_sticky_r <= (rd_errq ? 5'h00 : err_sticky_r) | err_ev;
			if (rd_errq)
				err_count_r <= 8'(|err_ev);
			else if (|err_ev && err_count_r != 8'hff)
				err_count_r <= err_count_r + 8'h01;
		end
	end
	assign rd_mux = ap_ofs_r == `OFS_CTRL ? {31'h0, gpib_fit_r}
		: ap_ofs_r == `OFS_GAP ? gap_r
		: ap_ofs_r == `OFS_IDLE ? idle_r
		: ap_ofs_r == `OFS_LIMLO ? {16'h0, lim_lo_r}
		: ap_ofs_r == `OFS_LIMHI ? {16'h0, lim_hi_r}
		: ap_ofs_r == `OFS_SETVAL ? {16'h0, setval_r}
		: ap_ofs_r == `OFS_STATUS ? {24'h0, st_r, proto_r, seq_bad_r, seq_ok_r, sock_open_i, 1'b0}
		: ap_ofs_r == `OFS_ERRQ ? {19'h0, err_count_r, err_sticky_r}
		: ap_ofs_r == `OFS_SEQ_START ? seq_start_r
		: ap_ofs_r == `OFS_SEQ_END ? seq_end_r
		: ap_ofs_r == `OFS_SEQ_TIME ? seq_time_r
		: ap_ofs_r == `OFS_SEQ_RATED ? seq_rated_r
		: 32'h0;
	assign hrdata_o = ap_rd_r ? rd_mux : 32'h0;
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	AST_TERM_DONE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(term && !bad_r) |=> msg_done_o) else $error("terminator did not end message");
	AST_GAP_WAIT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(rx_valid_i && st_r == ST_BODY && !term) |=> !msg_done_o) else $error("early hand-off");
	AST_GAP_RESTART: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		rx_valid_i |=> gap_cnt_r == 32'h0) else $error("gap counter not restarted");
	AST_LIMIT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(wr_set && !set_ok) |=> setval_r == $past(setval_r) && err_sticky_r[`ERR_LIMIT])
		else $error("out of limit value taken");
	AST_MBUS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(first && !is_mtcp && mbus_err) |=> bad_r) else $error("bad first byte accepted");
	AST_PORT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(first && is_mtcp && txt_first) |=> err_sticky_r[`ERR_PORT])
		else $error("text on reserved port not flagged");
	AST_CLOSE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		sock_close_o |-> $past(sock_open_i) && !$past(rx_valid_i))
		else $error("socket closed while busy");
	AST_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(err_sticky_r != 5'h00 && !rd_errq) |=> err_sticky_r != 5'h00)
		else $error("error lost before query");
	AST_RES: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		applied_code_o[0] == 1'b0) else $error("odd applied code");
	AST_SLOPE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(seq_eval_r && slope_bad) |=> seq_bad_r) else $error("flat slope accepted");
	COV_TEXT: cover property (@(posedge sys_clk_i) disable iff (rst_i)
		msg_done_o && msg_proto_o == PROTO_TEXT);
	COV_BIN: cover property (@(posedge sys_clk_i) disable iff (rst_i)
		msg_done_o && msg_proto_o == PROTO_BIN);
	COV_CLOSE: cover property (@(posedge sys_clk_i) disable iff (rst_i) sock_close_o);
	COV_REJ: cover property (@(posedge sys_clk_i) disable iff (rst_i) wr_set && !set_ok);
endmodule

/* tb/host_link_model.sv */
// Purpose: host side of the byte link, sends messages and opens sockets
// Assumes: bytes launched right after a rising edge, one-cycle strobe
// Notes: a released byte line carries the inverse of the last byte
module host_link_model
(
	input wire logic clk_i,
	output logic rx_valid_o,
	output logic [7:0] rx_byte_o,
	output logic [1:0] rx_port_o,
	output logic sock_open_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int cyc = 0;
	initial begin
		rx_valid_o = 1'b0;
		rx_byte_o = 8'h00;
		rx_port_o = 2'h0;
		sock_open_o = 1'b0;
	end
	always @(posedge clk_i) cyc <= cyc + 1;
	// byte 0 in bits 31:24; spacing kept below the gap timeout
	task automatic send(input logic [1:0] port, input int n, input logic [31:0] d,
		input int gap, output int last);
		logic [7:0] b;
		for (int i = 0; i < n; i++) begin
			b = d[31 - 8 * i -: 8];
			@(posedge clk_i);
			rx_valid_o <= 1'b1;
			rx_byte_o <= b;
			rx_port_o <= port;
			@(posedge clk_i);
			last = cyc;
			rx_valid_o <= 1'b0;
			rx_byte_o <= ~b; // no stale byte on an idle line
			repeat (gap) @(posedge clk_i);
		end
	endtask
	task automatic set_sock(input logic v);
		@(posedge clk_i);
		sock_open_o <= v;
	endtask
endmodule

/* tb/remote_message_front_end_tb_top.sv */
// Purpose: self-checking bench of the remote message front end
// Assumes: short gap and idle counts through parameters
// Notes: message cases in a table, register and socket cases by hand
`include "msg_front_consts.svh"
`define ck(nm, got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_total++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module remote_message_front_end_tb_top;
	import msg_front_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int GAP = 20;
	localparam int IDLE = 100;
	typedef struct {logic [1:0] port; int n; logic [31:0] d; int gap; logic done;
		logic [1:0] proto; logic [7:0] len; int lat; logic [4:0] err;} row_s;
	logic clk = 0, rst = 1, hsel = 0, hwrite = 0, got = 0;
	logic [31:0] haddr = 0, hwdata = 0, q;
	logic [1:0] htrans = 0, gp;
	logic [2:0] hsize = 3'h2;
	logic [7:0] gl;
	wire logic [31:0] hrdata;
	wire logic hready, hresp, msg_done, sock_close, rxv, sopen;
	wire logic [1:0] msg_proto, rxp;
	wire logic [7:0] msg_len, rxb;
	wire logic [15:0] applied;
	int err_total = 0, cmp_count = 0, dcyc, last, n;
	// ------------------------------------------------------------
	// message table: 0 usb, 1 net, 2 reserved tcp, 3 gpib
	// ------------------------------------------------------------
	row_s rows[11] = '{
		'{2'd0, 3, 32'h2a410a00, 2, 1'b1, PROTO_TEXT, 8'd3, 1, 5'h00},
		'{2'd0, 3, 32'h2a410d00, 2, 1'b1, PROTO_TEXT, 8'd3, 1, 5'h00},
		'{2'd0, 3, 32'h00060100, 2, 1'b1, PROTO_BIN, 8'd3, 0, 5'h00},
		'{2'd1, 2, 32'h2a420000, 15, 1'b1, PROTO_TEXT, 8'd2, 0, 5'h00},
		'{2'd1, 2, 32'h00030000, 2, 1'b1, PROTO_BIN, 8'd2, 0, 5'h00},
		'{2'd2, 4, 32'h00000000, 2, 1'b1, PROTO_MTCP, 8'd4, 0, 5'h00},
		'{2'd0, 1, 32'h29000000, 2, 1'b0, PROTO_NONE, 8'd0, 0, 5'h03},
		'{2'd0, 2, 32'h01410000, 2, 1'b0, PROTO_NONE, 8'd0, 0, 5'h03},
		'{2'd2, 2, 32'h2a410000, 2, 1'b0, PROTO_NONE, 8'd0, 0, 5'h11},
		'{2'd3, 2, 32'h00010000, 2, 1'b0, PROTO_NONE, 8'd0, 0, 5'h01},
		'{2'd3, 3, 32'h2a410a00, 2, 1'b1, PROTO_TEXT, 8'd3, 1, 5'h00}};
	always #20 clk = ~clk;
	host_link_model host (.clk_i(clk), .rx_valid_o(rxv), .rx_byte_o(rxb), .rx_port_o(rxp),
		.sock_open_o(sopen));
	remote_message_front_end #(.GAP_CYC(32'd20), .IDLE_CYC(32'd100)) dut (.sys_clk_i(clk),
		.rst_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
		.hreadyout_o(hready), .hresp_o(hresp), .rx_valid_i(rxv), .rx_byte_i(rxb),
		.rx_port_i(rxp),
		.sock_open_i(sopen), .msg_done_o(msg_done), .msg_proto_o(msg_proto),
		.msg_len_o(msg_len), .sock_close_o(sock_close), .applied_code_o(applied));
	always @(posedge clk) if (msg_done === 1'b1) begin
		got <= 1'b1;
		gp <= msg_proto;
		gl <= msg_len;
		dcyc <= host.cyc;
	end
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		q = hrdata;
	endtask
	task automatic wait_close();
		n = 0;
		while (sock_close !== 1'b1 && n < 300) begin
			@(posedge clk);
			n++;
		end
		`ck("close", (n >= IDLE && n <= IDLE + 3), 1'b1)
	endtask
	task conclude();
		if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		conclude();
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		`ck("idle", {msg_done, sock_close, applied, hready, hresp}, 19'h00002)
		bus(1'b0, `OFS_LIMHI, 0);
		`ck("limhi", q, 32'h0000cccc)
		bus(1'b1, `OFS_GAP, GAP);
		foreach (rows[i]) begin
			got = 1'b0;
			host.send(rows[i].port, rows[i].n, rows[i].d, rows[i].gap, last);
			repeat (GAP + 6) @(posedge clk);
			`ck("done", got, rows[i].done)
			if (rows[i].done) begin
				`ck("proto", gp, rows[i].proto)
				`ck("len", gl, rows[i].len)
				if (rows[i].lat > 0) `ck("lat", dcyc - last, rows[i].lat)
				else `ck("gap", (dcyc - last >= GAP && dcyc - last <= GAP + 3), 1'b1)
			end
			bus(1'b0, `OFS_ERRQ, 0);
			if (rows[i].port == 2'd3) `ck("err", q[4:0], rows[i].err)
			else `ck("err", q[4:0], rows[i].err)
		end
		bus(1'b1, `OFS_GAP, 30);
		bus(1'b1, `OFS_GAP, 40);
		got = 1'b0;
		host.send(2'd0, 2, 32'h2a420000, 30, last);
		repeat (50) @(posedge clk);
		`ck("gap40", (got && dcyc - last >= 40 && dcyc - last <= 43), 1'b1)
		bus(1'b1, `OFS_LIMLO, 32'h100);
		bus(1'b1, `OFS_LIMHI, 32'h8000);
		bus(1'b1, `OFS_SETVAL, 32'h1235);
		bus(1'b1, `OFS_SETVAL, 32'h9000);
		bus(1'b0, `OFS_SETVAL, 0);
		`ck("readback", q, 32'h1235)
		`ck("applied", applied, 16'h1234)
		bus(1'b0, `OFS_ERRQ, 0);
		`ck("limerr", q[4:0], 5'h04)
		bus(1'b0, `OFS_ERRQ, 0);
		`ck("errclr", q[4:0], 5'h00)
		bus(1'b1, `OFS_LIMHI, 32'hcccc);
		bus(1'b1, `OFS_SETVAL, 32'hcccd);
		bus(1'b1, `OFS_SETVAL, 32'hcccc);
		bus(1'b0, `OFS_ERRQ, 0);
		`ck("full", {applied, q[2]}, 17'h19999)
		bus(1'b1, `OFS_SEQ_RATED, 1000);
		for (int k = 0; k < 3; k++) begin
			bus(1'b1, `OFS_SEQ_START, (k == 2) ? 2 : 0);
			bus(1'b1, `OFS_SEQ_END, (k == 0) ? 1 : (k == 1) ? 2 : 0);
			bus(1'b1, `OFS_SEQ_TIME, 2);
			repeat (3) @(posedge clk);
			bus(1'b0, `OFS_STATUS, 0);
			`ck("slope", q[3:2], (k == 0) ? 2'b10 : 2'b01)
		end
		bus(1'b0, 32'h0fc, 0);
		`ck("unmapped", q, 32'h0)
		host.set_sock(1'b1);
		wait_close();
		host.set_sock(1'b0);
		repeat (5) @(posedge clk);
		host.set_sock(1'b1);
		wait_close();
		conclude();
	end
endmodule
